/* File: pkg/csr_pkg.sv */
// constants, carriers and state layout for the memory interface debug register bank
// Notes on behaviour
// R01 - host writing one to control bit 0 starts a memory interface soft reset
// R02 - the soft reset request bit clears itself once the reset sequence ends
// R03 - control bit 24 mirrors calibration pass, read only, writes ignored
// R04 - control bit 25 mirrors calibration failure, read only, writes ignored
// R05 - score word bits 7:0 show the read health score, read only
// R06 - score word bits 23:16 show the write health score, read only
// R07 - host trusts both health scores only while the pass bit reads one
// R08 - failure word bits 7:0 show the stage where calibration first failed
// R09 - failure word bits 23:16 show the group calibrating at first failure
// R10 - host trusts failing stage and group only while the failure bit reads one
// R11 - strobe map word holds one bit per group, set when strobe edges were seen
// R12 - words one and two and all reserved bit ranges read as zero
// R13 - health score is the sum over groups of dq minimum plus strobe margin, halved
// R14 - clock generator locked status is readable by the host
// R15 - the register port serves a jtag driven bus master
// R16 - calibration failure input is active high
// R17 - calibration pass input is active high
// R18 - soft reset request bit reads one while the reset sequence is running
package csr_pkg;

	// word indices; byte address is four times the index
	localparam logic [9:0] IDX_RESERVED_A   = 10'h001;
	localparam logic [9:0] IDX_RESERVED_B   = 10'h002;
	localparam logic [9:0] IDX_RESET_CALIB  = 10'h004;
	localparam logic [9:0] IDX_HEALTH       = 10'h005;
	localparam logic [9:0] IDX_FAIL_LOC     = 10'h006;
	localparam logic [9:0] IDX_STROBE_MAP   = 10'h007;
	localparam logic [9:0] IDX_CLOCK_STATUS = 10'h008;

	// field positions
	localparam int BIT_SOFT_RESET   = 0;
	localparam int BIT_CAL_PASS     = 24;
	localparam int BIT_CAL_FAIL     = 25;
	localparam int BIT_PLL_LOCKED   = 0;
	localparam int LSB_LOW_FIELD    = 0;
	localparam int LSB_HIGH_FIELD   = 16;

	// cycles that the soft reset request is held before waiting for completion
	localparam logic [7:0] SOFT_RESET_HOLD_CYCLES = 8'h04;

	// reset values and the score saturation limit
	localparam logic [15:0] SUM_RESET   = 16'h0000;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
	localparam logic [7:0]  SCORE_MAX   = 8'hff;

	typedef enum logic [1:0] {
		RST_IDLE = 2'b00,
		RST_HOLD = 2'b01,
		RST_WAIT = 2'b10
	} reset_fsm_t;

	// one register port request, byte addressed
	typedef struct packed {
		logic        read;
		logic        write;
		logic [11:0] address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} csr_req_t;

	// calibration outcome from the sequencer, same clock
	typedef struct packed {
		logic       success;
		logic       fail;
		logic [7:0] fail_stage;
		logic [7:0] fail_group;
	} calib_report_t;

	// one per-group margin sample from the sequencer
	typedef struct packed {
		logic       valid;
		logic       is_write;
		logic [7:0] dq_min;
		logic [7:0] dqs;
	} margin_sample_t;

	typedef struct packed {
		reset_fsm_t  fsm;
		logic [7:0]  hold_cnt;
		logic [15:0] read_sum;
		logic [15:0] write_sum;
		logic [31:0] rdata;
		logic        rvalid;
		logic        lock_meta;
		logic        lock_sync;
	} state_t;

endpackage

/* File: logic/memory_iface_debug_csr.sv */
// register bank for debug access to a calibrated memory interface
module memory_iface_debug_csr import csr_pkg::*; #(
	parameter int GROUPS = 32
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire csr_req_t          csr_req,
	output logic [31:0]            csr_readdata,
	output logic                   csr_readdatavalid,
	input  wire calib_report_t     calib,
	input  wire margin_sample_t    margin,
	input  wire logic [GROUPS-1:0] dqs_seen,
	input  wire logic              pll_locked,
	input  wire logic              reset_done,
	output logic                   soft_reset_out
);

	state_t state_reg;
	state_t state_next;

	logic        busy;
	logic        ctrl_write;
	logic        start_reset;
	logic [7:0]  read_health_score;
	logic [7:0]  write_health_score;
	logic [31:0] rd_word;
	logic [31:0] strobe_word;

	// word select: exact aligned byte address of an index
	function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
		return (addr[11:2] == idx) && (addr[1:0] == 2'b00);
	endfunction

	// halve a margin sum, saturating to the 8-bit field
	function automatic logic [7:0] score(input logic [15:0] sum);
		logic [14:0] half;
		half = sum[15:1];
		return (half > 15'(SCORE_MAX)) ? SCORE_MAX : half[7:0];
	endfunction

	// decode helpers shared by the next-state logic and read mux
	assign busy               = (state_reg.fsm != RST_IDLE);
	assign ctrl_write         = csr_req.write && csr_req.byteenable[0]
	                            && hit(csr_req.address, IDX_RESET_CALIB);
	assign start_reset        = ctrl_write && csr_req.writedata[BIT_SOFT_RESET]; // see R01
	assign read_health_score  = score(state_reg.read_sum);  // see R13
	assign write_health_score = score(state_reg.write_sum); // see R13
	assign strobe_word        = 32'(dqs_seen);              // see R11

	// read mux; anything unmapped or reserved reads zero
	always_comb begin
		rd_word = 32'h0000_0000; // see R12
		if (hit(csr_req.address, IDX_RESET_CALIB)) begin
			rd_word[BIT_SOFT_RESET] = busy;         // see R18
			rd_word[BIT_CAL_PASS]   = calib.success; // see R03 see R17
			rd_word[BIT_CAL_FAIL]   = calib.fail;    // see R04 see R16
		end else if (hit(csr_req.address, IDX_HEALTH)) begin
			rd_word[LSB_LOW_FIELD +: 8]  = read_health_score;  // see R05
			rd_word[LSB_HIGH_FIELD +: 8] = write_health_score; // see R06
		end else if (hit(csr_req.address, IDX_FAIL_LOC)) begin
			rd_word[LSB_LOW_FIELD +: 8]  = calib.fail_stage; // see R08
			rd_word[LSB_HIGH_FIELD +: 8] = calib.fail_group; // see R09
		end else if (hit(csr_req.address, IDX_STROBE_MAP)) begin
			rd_word = strobe_word; // see R11
		end else if (hit(csr_req.address, IDX_CLOCK_STATUS)) begin
			rd_word[BIT_PLL_LOCKED] = state_reg.lock_sync; // see R14
		end
	end

	// next state: soft reset sequencer, margin sums, read pipeline, lock sync
	always_comb begin
		state_next = state_reg;

		// locked flag comes from another clock, so two flops first
		state_next.lock_meta = pll_locked;
		state_next.lock_sync = state_reg.lock_meta;

		// single cycle read latency, no wait states for the jtag master
		state_next.rvalid = csr_req.read; // see R15
		state_next.rdata  = csr_req.read ? rd_word : state_reg.rdata;

		case (state_reg.fsm)
			RST_IDLE: begin
				if (start_reset) begin // see R01
					state_next.fsm      = RST_HOLD;
					state_next.hold_cnt = SOFT_RESET_HOLD_CYCLES;
				end
			end
			RST_HOLD: begin
				// done is not trusted until the request has been seen
				if (state_reg.hold_cnt == 8'h01) begin
					state_next.fsm = RST_WAIT;
				end
				state_next.hold_cnt = state_reg.hold_cnt - 8'h01;
			end
			RST_WAIT: begin
				// a new request in the same cycle as done wins over the clear
				if (start_reset) begin
					state_next.fsm      = RST_HOLD;
					state_next.hold_cnt = SOFT_RESET_HOLD_CYCLES;
				end else if (reset_done) begin
					state_next.fsm = RST_IDLE; // see R02
				end
			end
			default: begin
				state_next.fsm      = RST_IDLE;
				state_next.hold_cnt = 8'h00;
			end
		endcase

		// a fresh reset restarts calibration, so old sums are dropped
		if (start_reset && (state_reg.fsm != RST_HOLD)) begin
			state_next.read_sum  = SUM_RESET;
			state_next.write_sum = SUM_RESET;
		end else if (margin.valid) begin
			// sums saturate instead of wrapping on absurd group counts
			if (margin.is_write) begin
				state_next.write_sum = (state_reg.write_sum > 16'hfc00) ? 16'hffff
					: state_reg.write_sum + {8'h00, margin.dq_min} + {8'h00, margin.dqs}; // see R13
			end else begin
				state_next.read_sum = (state_reg.read_sum > 16'hfc00) ? 16'hffff
					: state_reg.read_sum + {8'h00, margin.dq_min} + {8'h00, margin.dqs}; // see R13
			end
		end
	end

	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg.fsm       <= RST_IDLE;
			state_reg.hold_cnt  <= 8'h00;
			state_reg.read_sum  <= SUM_RESET;
			state_reg.write_sum <= SUM_RESET;
			state_reg.rdata     <= RDATA_RESET;
			state_reg.rvalid    <= 1'b0;
			state_reg.lock_meta <= 1'b0;
			state_reg.lock_sync <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// read outputs straight from flops, soft reset decoded from the state flops
	assign csr_readdata      = state_reg.rdata;
	assign csr_readdatavalid = state_reg.rvalid;
	assign soft_reset_out    = (state_reg.fsm == RST_HOLD); // see R01

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_reset_start: assert property ( // see R01
		(!busy && start_reset) |=> soft_reset_out [*4] ##1 !soft_reset_out)
		else $error("soft reset request not held for four cycles");

	a_reset_clears: assert property ( // see R02
		(state_reg.fsm == RST_WAIT && reset_done && !start_reset) |=> !busy)
		else $error("soft reset bit did not clear after done");

	a_busy_reads: assert property ( // see R18
		(csr_req.read && hit(csr_req.address, IDX_RESET_CALIB) && busy)
		|=> csr_readdatavalid && csr_readdata[0])
		else $error("soft reset bit not readable as one while busy");

	a_pass_mirror: assert property ( // see R03
		(csr_req.read && hit(csr_req.address, IDX_RESET_CALIB))
		|=> csr_readdata[24] == $past(calib.success))
		else $error("pass bit does not mirror calibration pass");

	a_fail_mirror: assert property ( // see R04
		(csr_req.read && hit(csr_req.address, IDX_RESET_CALIB))
		|=> csr_readdata[25] == $past(calib.fail) && csr_readdata[23:1] == 23'h0)
		else $error("fail bit does not mirror calibration failure");

	a_score_read: assert property ( // see R05
		(csr_req.read && hit(csr_req.address, IDX_HEALTH))
		|=> csr_readdata[7:0] == $past(read_health_score)
		&& csr_readdata[23:16] == $past(write_health_score)
		&& csr_readdata[15:8] == 8'h00)
		else $error("health score word wrong");

	a_score_sum: assert property ( // see R13
		(margin.valid && !margin.is_write && !start_reset && state_reg.read_sum < 16'hfc00)
		|=> state_reg.read_sum == $past(state_reg.read_sum)
		+ {8'h00, $past(margin.dq_min)} + {8'h00, $past(margin.dqs)})
		else $error("read margin sum not accumulated");

	a_fail_location: assert property ( // see R08
		(csr_req.read && hit(csr_req.address, IDX_FAIL_LOC))
		|=> csr_readdata == {8'h00, $past(calib.fail_group), 8'h00, $past(calib.fail_stage)})
		else $error("failure location word wrong");

	a_strobe_map: assert property ( // see R11
		(csr_req.read && hit(csr_req.address, IDX_STROBE_MAP))
		|=> csr_readdata == $past(strobe_word))
		else $error("strobe map word wrong");

	a_reserved_zero: assert property ( // see R12
		(csr_req.read && (hit(csr_req.address, IDX_RESERVED_A)
		|| hit(csr_req.address, IDX_RESERVED_B))) |=> csr_readdata == 32'h0)
		else $error("reserved word not zero");

	a_lock_visible: assert property ( // see R14
		(csr_req.read && hit(csr_req.address, IDX_CLOCK_STATUS))
		|=> csr_readdata == {31'h0, $past(state_reg.lock_sync)})
		else $error("locked status not shown");

	// register port timing: one pulse per read, data held between reads
	a_valid_after_read: assert property ( // see R15
		csr_req.read |=> csr_readdatavalid)
		else $error("read not answered in one cycle");

	a_valid_one_cycle: assert property ( // see R15
		!csr_req.read |=> !csr_readdatavalid)
		else $error("read valid without a read");

	a_data_stands: assert property ( // see R15
		!csr_req.read |=> $stable(csr_readdata))
		else $error("read data changed without a read");

	// control word fields; calibration levels are active high
	a_pass_level: assert property ( // see R17
		(csr_req.read && hit(csr_req.address, IDX_RESET_CALIB) && calib.success)
		|=> csr_readdata[BIT_CAL_PASS])
		else $error("pass level not shown as one");

	a_fail_level: assert property ( // see R16
		(csr_req.read && hit(csr_req.address, IDX_RESET_CALIB) && calib.fail)
		|=> csr_readdata[BIT_CAL_FAIL])
		else $error("fail level not shown as one");

	a_busy_idle: assert property ( // see R02
		(csr_req.read && hit(csr_req.address, IDX_RESET_CALIB) && !busy)
		|=> !csr_readdata[BIT_SOFT_RESET])
		else $error("soft reset bit reads one while idle");

	a_ctrl_top_zero: assert property ( // see R12
		(csr_req.read && hit(csr_req.address, IDX_RESET_CALIB))
		|=> csr_readdata[31:26] == 6'h00)
		else $error("control word top bits not zero");

	// score, failure and strobe words
	a_score_top_zero: assert property ( // see R12
		(csr_req.read && hit(csr_req.address, IDX_HEALTH))
		|=> csr_readdata[31:24] == 8'h00)
		else $error("score word top bits not zero");

	a_score_write: assert property ( // see R06
		(csr_req.read && hit(csr_req.address, IDX_HEALTH))
		|=> csr_readdata[LSB_HIGH_FIELD +: 8] == $past(write_health_score))
		else $error("write health score field wrong");

	a_stage_field: assert property ( // see R08
		(csr_req.read && hit(csr_req.address, IDX_FAIL_LOC))
		|=> csr_readdata[LSB_LOW_FIELD +: 8] == $past(calib.fail_stage))
		else $error("failing stage field wrong");

	a_group_field: assert property ( // see R09
		(csr_req.read && hit(csr_req.address, IDX_FAIL_LOC))
		|=> csr_readdata[LSB_HIGH_FIELD +: 8] == $past(calib.fail_group))
		else $error("failing group field wrong");

	a_strobe_groups: assert property ( // see R11
		(csr_req.read && hit(csr_req.address, IDX_STROBE_MAP))
		|=> csr_readdata[GROUPS-1:0] == $past(dqs_seen))
		else $error("strobe group bits wrong");

	// unaligned and unmapped addresses fall through to zero
	a_unmapped_zero: assert property ( // see R12
		(csr_req.read && !hit(csr_req.address, IDX_RESET_CALIB)
		&& !hit(csr_req.address, IDX_HEALTH)
		&& !hit(csr_req.address, IDX_FAIL_LOC)
		&& !hit(csr_req.address, IDX_STROBE_MAP)
		&& !hit(csr_req.address, IDX_CLOCK_STATUS))
		|=> csr_readdata == 32'h0)
		else $error("unmapped word not zero");

	// margin sums and the halved scores
	a_write_sum: assert property ( // see R13
		(margin.valid && margin.is_write && !start_reset
		&& state_reg.write_sum < 16'hfc00)
		|=> state_reg.write_sum == $past(state_reg.write_sum)
		+ {8'h00, $past(margin.dq_min)} + {8'h00, $past(margin.dqs)})
		else $error("write margin sum not accumulated");

	a_read_halved: assert property ( // see R13
		(state_reg.read_sum < 16'h0200)
		|-> read_health_score == state_reg.read_sum[8:1])
		else $error("read score is not half the sum");

	a_write_halved: assert property ( // see R13
		(state_reg.write_sum < 16'h0200)
		|-> write_health_score == state_reg.write_sum[8:1])
		else $error("write score is not half the sum");

	a_sum_clear: assert property ( // see R13
		(start_reset && state_reg.fsm != RST_HOLD)
		|=> state_reg.read_sum == SUM_RESET
		&& state_reg.write_sum == SUM_RESET)
		else $error("margin sums not cleared by a soft reset");

	a_sum_hold: assert property ( // see R13
		(!margin.valid && !start_reset)
		|=> $stable(state_reg.read_sum) && $stable(state_reg.write_sum))
		else $error("margin sum moved without a sample");

	// locked status crosses two flops
	a_lock_delay: assert property ( // see R14
		$rose(state_reg.lock_sync) |-> $past(pll_locked, 2))
		else $error("locked status rose without the pin");

	// soft reset sequencer
	a_hold_start: assert property ( // see R01
		(!busy && start_reset)
		|=> state_reg.hold_cnt == SOFT_RESET_HOLD_CYCLES)
		else $error("hold count not loaded");

	a_hold_count: assert property ( // see R01
		(state_reg.fsm == RST_HOLD)
		|=> state_reg.hold_cnt == $past(state_reg.hold_cnt) - 8'h01)
		else $error("hold count not stepping down");

	a_restart_hold: assert property ( // see R01
		(state_reg.fsm == RST_WAIT && start_reset)
		|=> soft_reset_out
		&& state_reg.hold_cnt == SOFT_RESET_HOLD_CYCLES)
		else $error("request while waiting did not restart the hold");

	a_wait_holds: assert property ( // see R02
		(state_reg.fsm == RST_WAIT && !start_reset && !reset_done)
		|=> state_reg.fsm == RST_WAIT)
		else $error("soft reset bit cleared before the sequence ended");

	a_idle_quiet: assert property ( // see R01
		(!busy && !start_reset) |=> !busy)
		else $error("soft reset started without a request");

	a_write_flag: assert property ( // see R01
		(!busy && ctrl_write && !csr_req.writedata[BIT_SOFT_RESET])
		|=> !busy)
		else $error("control write without bit zero started a reset");

	a_other_write: assert property ( // see R12
		(!busy && csr_req.write && !hit(csr_req.address, IDX_RESET_CALIB))
		|=> !busy)
		else $error("write to another word started a reset");

endmodule

/* File: test/reset_seq_model.sv */
// behavioural model of the memory interface reset sequence behind the register bank
module reset_seq_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       soft_reset_out,
	input  wire logic [7:0] latency,
	output logic            reset_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt;

	// reset sequence ends a chosen number of cycles after the request drops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			reset_done <= 1'b0;
		end else begin
			reset_done <= 1'b0;
			if (soft_reset_out) begin
				cnt <= latency;
			end else if (cnt == 8'h01) begin
				reset_done <= 1'b1;
				cnt <= 8'h00;
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

/* File: test/memory_iface_debug_csr_tb_top.sv */
// self-checking bench for the memory interface debug register bank
module memory_iface_debug_csr_tb_top;
	import csr_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic           clk;
	logic           rst;
	csr_req_t       csr_req;
	logic [31:0]    csr_readdata;
	logic           csr_readdatavalid;
	calib_report_t  calib;
	margin_sample_t margin;
	logic [31:0]    dqs_seen;
	logic           pll_locked;
	logic           reset_done;
	logic           soft_reset_out;
	logic [7:0]     latency;
	int             miscompares;
	int             checks_done;
	logic [31:0]    rd;

	memory_iface_debug_csr dut (.clk(clk), .rst(rst), .csr_req(csr_req),
		.csr_readdata(csr_readdata), .csr_readdatavalid(csr_readdatavalid), .calib(calib),
		.margin(margin), .dqs_seen(dqs_seen), .pll_locked(pll_locked),
		.reset_done(reset_done), .soft_reset_out(soft_reset_out));
	reset_seq_model partner (.clk(clk), .rst(rst), .soft_reset_out(soft_reset_out),
		.latency(latency), .reset_done(reset_done));

	// free-running 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one read: strobe for one cycle, valid and data one cycle later
	task automatic csr_read(input logic [11:0] addr, output logic [31:0] data);
		@(posedge clk);
		csr_req.read <= 1'b1;
		csr_req.address <= addr;
		@(posedge clk);
		csr_req.read <= 1'b0;
		#1;
		chk({31'h0, csr_readdatavalid}, 32'h1);
		data = csr_readdata;
	endtask

	task automatic csr_write(input logic [11:0] addr, input logic [31:0] data);
		@(posedge clk);
		csr_req.write <= 1'b1;
		csr_req.address <= addr;
		csr_req.writedata <= data;
		csr_req.byteenable <= 4'hf;
		@(posedge clk);
		csr_req.write <= 1'b0;
	endtask

	task automatic read_chk(input logic [11:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		csr_read(addr, d);
		chk(d, exp);
	endtask

	// one margin sample pulse
	task automatic push(input logic w, input logic [7:0] dq, input logic [7:0] s);
		@(posedge clk);
		margin <= '{valid: 1'b1, is_write: w, dq_min: dq, dqs: s};
		@(posedge clk);
		margin.valid <= 1'b0;
	endtask

	// soft reset, then poll the busy bit under a bound; sums are cleared by it
	// a restarted calibration drops pass and fail, so the control word reads bit 0 only
	task automatic soft_reset(input logic [7:0] lat, input logic again);
		int n;
		calib <= '0;
		latency <= lat;
		csr_write(12'h010, 32'h0000_0001);
		if (again) begin
			// second request lands in the waiting phase and restarts the hold
			repeat (5) @(posedge clk);
			csr_write(12'h010, 32'h0000_0001);
		end
		#1;
		chk({31'h0, soft_reset_out}, 32'h1);
		read_chk(12'h010, 32'h0000_0001);
		n = 0;
		rd = 32'h1;
		while (rd[0] !== 1'b0 && n < 60) begin
			csr_read(12'h010, rd);
			n++;
		end
		if (rd[0] !== 1'b0) begin
			// sequence never finished: count it and stop
			miscompares++;
			end_sim();
		end
		chk(rd, 32'h0000_0000);
		chk({31'h0, soft_reset_out}, 32'h0);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		miscompares = 0;
		checks_done = 0;
		rst = 1'b1;
		csr_req = '0;
		calib = '0;
		margin = '0;
		dqs_seen = 32'h0;
		pll_locked = 1'b0;
		latency = 8'h01;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// reserved and unmapped words read zero, writes there have no effect
		csr_write(12'h004, 32'hffff_ffff);
		read_chk(12'h004, 32'h0);
		read_chk(12'h008, 32'h0);
		read_chk(12'h03c, 32'h0);
		read_chk(12'h010, 32'h0);
		$display("test reserved done");
		// calibration outcome mirrored; writes to the mirror bits ignored
		calib <= '{success: 1'b1, fail: 1'b0, fail_stage: 8'h03, fail_group: 8'h1e};
		csr_write(12'h010, 32'hfeff_fffe);
		read_chk(12'h010, 32'h0100_0000);
		calib <= '{success: 1'b0, fail: 1'b1, fail_stage: 8'h03, fail_group: 8'h1e};
		read_chk(12'h010, 32'h0200_0000);
		read_chk(12'h018, 32'h001e_0003);
		$display("test calibration done");
		dqs_seen <= 32'ha5c3_0f81;
		read_chk(12'h01c, 32'ha5c3_0f81);
		read_chk(12'h01e, 32'h0);
		pll_locked <= 1'b1;
		repeat (3) @(posedge clk);
		read_chk(12'h020, 32'h0000_0001);
		$display("test status done");
		// scores are only trusted once the pass bit reads one
		calib <= '{success: 1'b1, fail: 1'b0, fail_stage: 8'h00, fail_group: 8'h00};
		read_chk(12'h010, 32'h0100_0000);
		// read sum 100 halves to 0x32, write sum 300 halves to 0x96
		push(1'b0, 8'd10, 8'd20);
		push(1'b0, 8'd30, 8'd40);
		push(1'b1, 8'd200, 8'd100);
		read_chk(12'h014, 32'h0096_0032);
		$display("test scores done");
		// prompt and slow reset sequences
		soft_reset(8'h01, 1'b0);
		read_chk(12'h014, 32'h0);
		soft_reset(8'h14, 1'b1);
		$display("test soft reset done");
		end_sim();
	end

	// hang guard
	initial begin
		#2000000;
		miscompares++;
		end_sim();
	end
endmodule
